// ===== sfb_map.vh
// Constants for the serial-flash boot reader
`ifndef SFB_MAP_VH
`define SFB_MAP_VH
// Configuration reset values and minimum clock divider
`define SFB_DIV_RST 5'h1f
`define SFB_WIDE_RST 1'b0
`define SFB_QUICK_RST 1'b0
`define SFB_GAP_RST 4'hf
`define SFB_DIV_MIN 5'h02
// Field positions in the configuration read-back word
`define SFB_CFG_DIV_LSB 0
`define SFB_CFG_WIDE_BIT 5
`define SFB_CFG_QUICK_BIT 6
`define SFB_CFG_GAP_LSB 7
// Flash commands
`define SFB_CMD_READ 8'h03
`define SFB_CMD_QUICK 8'h0b
// Interface owner code that selects this controller
`define SFB_OWNER_BOOT 2'h1
// Access sizes
`define SFB_SIZE_BYTE 2'h0
`define SFB_SIZE_HALF 2'h1
// Bits per data word and per command, each less one; the dummy count is exact
`define SFB_WORD_BITS 6'h1f
`define SFB_BITS_CMD_NARROW 6'h1f
`define SFB_BITS_CMD_WIDE 6'h27
`define SFB_BITS_DUMMY 6'h08
`endif

// ===== sfb_reader.v
// Serial-flash boot reader: memory window reads turned into flash reads
`timescale 1ns/1ps
`default_nettype none
`include "sfb_map.vh"

module sfb_reader (
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  input wire rd_req,
  input wire [27:0] rd_addr,
  input wire [1:0] rd_size,
  output reg rd_ack,
  output reg rd_err,
  output reg [31:0] rd_data,
  input wire wr_req,
  output reg wr_err,
  input wire cfg_wr,
  input wire [4:0] cfg_clk_div,
  input wire cfg_wide_address_enable,
  input wire cfg_quick_read_enable,
  input wire [3:0] cfg_select_idle_gap,
  output reg [10:0] flash_read_config,
  input wire [1:0] si_owner,
  output reg busy,
  input wire manual_pin_enable,
  input wire man_clk,
  input wire man_clk_oe_n,
  input wire man_do,
  input wire man_do_oe_n,
  input wire [3:0] man_select_n,
  input wire [3:0] man_select_oe_n,
  output reg manual_data_in_level,
  output reg flash_clk,
  output reg flash_clk_oe_n,
  output reg flash_do,
  output reg flash_do_oe_n,
  output reg [3:0] flash_select_n,
  output reg [3:0] flash_select_oe_n,
  input wire serial_data_in
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SEND = 4'h2;
  localparam [3:0] S_DATA = 4'h4;
  localparam [3:0] S_HOLD = 4'h8;

  reg [3:0] state_q;
  reg [4:0] cfg_div_q;
  reg cfg_wide_q;
  reg cfg_quick_q;
  reg [3:0] cfg_gap_q;
  reg cfg_dirty_q;
  reg [4:0] act_div_q;
  reg act_wide_q;
  reg [4:0] div_cnt_q;
  reg [5:0] bit_cnt_q;
  reg [9:0] gap_cnt_q;
  reg [47:0] tx_q;
  reg [31:0] rx_q;
  reg sclk_q;
  reg cs_on_q;
  reg [1:0] cs_sel_q;
  reg [25:0] fetch_q;
  reg [31:0] buf_q;
  reg [25:0] buf_word_q;
  reg buf_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  wire owned = (si_owner == `SFB_OWNER_BOOT) && !manual_pin_enable;
  wire [25:0] rd_word = rd_addr[27:2];
  wire unmapped = !cfg_wide_q && (rd_addr[27:26] != 2'h0);
  wire want = rd_req && !rd_ack;
  wire hit = want && buf_valid_q && (buf_word_q == rd_word);
  wire miss = want && !unmapped && !hit;
  wire [1:0] want_sel = cfg_wide_q ? 2'h0 : rd_addr[25:24];
  wire bit_end = (div_cnt_q == act_div_q - 5'h01);
  wire [4:0] half = {1'b0, act_div_q[4:1]};
  wire [31:0] rx_next = {rx_q[30:0], serial_data_in};
  wire [31:0] word_le = {rx_next[7:0], rx_next[15:8], rx_next[23:16], rx_next[31:24]};
  wire [25:0] fetch_inc = fetch_q + 26'h1;
  wire slice_end = act_wide_q ? (fetch_q == 26'h0) : (fetch_q[21:0] == 22'h0);
  wire [4:0] div_use = (cfg_div_q < `SFB_DIV_MIN) ? `SFB_DIV_MIN : cfg_div_q;
  wire [9:0] gap_load = {6'h00, cfg_gap_q} * {5'h00, div_use};
  wire [7:0] cmd = cfg_quick_q ? `SFB_CMD_QUICK : `SFB_CMD_READ;
  wire [5:0] nbits = (cfg_wide_q ? `SFB_BITS_CMD_WIDE : `SFB_BITS_CMD_NARROW)
                     + (cfg_quick_q ? `SFB_BITS_DUMMY : 6'h00);
  wire [47:0] tx_load = cfg_wide_q ? {cmd, 4'h0, rd_addr[27:2], 2'h0, 8'h00}
                                   : {cmd, rd_addr[23:2], 2'h0, 16'h0000};
  wire abort = (state_q != S_IDLE) && (!owned || (miss && rd_word != fetch_q));

  reg [31:0] lane_mask;
  always @*
  begin
    case (rd_size)
      `SFB_SIZE_BYTE: lane_mask = 32'h000000ff << {rd_addr[1:0], 3'h0};
      `SFB_SIZE_HALF: lane_mask = rd_addr[1] ? 32'hffff0000 : 32'h0000ffff;
      default: lane_mask = 32'hffffffff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_div_q <= `SFB_DIV_RST;
      cfg_wide_q <= `SFB_WIDE_RST;
      cfg_quick_q <= `SFB_QUICK_RST;
      cfg_gap_q <= `SFB_GAP_RST;
      flash_read_config <= 11'h000;
    end
    else if (clk_en)
    begin
      if (cfg_wr)
      begin
        cfg_div_q <= cfg_clk_div;
        cfg_wide_q <= cfg_wide_address_enable;
        cfg_quick_q <= cfg_quick_read_enable;
        cfg_gap_q <= cfg_select_idle_gap;
      end
      flash_read_config <= {cfg_gap_q, cfg_quick_q, cfg_wide_q, cfg_div_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      cfg_dirty_q <= 1'b0;
      act_div_q <= `SFB_DIV_RST;
      act_wide_q <= `SFB_WIDE_RST;
      div_cnt_q <= 5'h00;
      bit_cnt_q <= 6'h00;
      gap_cnt_q <= 10'h000;
      tx_q <= 48'h000000000000;
      rx_q <= 32'h00000000;
      sclk_q <= 1'b0;
      cs_on_q <= 1'b0;
      cs_sel_q <= 2'h0;
      fetch_q <= 26'h0000000;
      buf_q <= 32'h00000000;
      buf_word_q <= 26'h0000000;
      buf_valid_q <= 1'b0;
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 32'h00000000;
      wr_err <= 1'b0;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      wr_err <= wr_req;
      busy <= (state_q != S_IDLE);
      if (gap_cnt_q != 10'h000)
        gap_cnt_q <= gap_cnt_q - 10'h001;
      if (cfg_wr)
        cfg_dirty_q <= 1'b1;
      if (want && unmapped)
      begin
        rd_ack <= 1'b1;
        rd_err <= 1'b1;
        rd_data <= 32'h00000000;
      end
      else if (hit)
      begin
        rd_ack <= 1'b1;
        rd_data <= buf_q & lane_mask;
      end
      if (cfg_wr || !owned)
        buf_valid_q <= 1'b0;
      else if (hit)
        buf_valid_q <= 1'b0;
      if (abort || (state_q == S_HOLD && (cfg_dirty_q || slice_end)))
      begin
        state_q <= S_IDLE;
        cs_on_q <= 1'b0;
        sclk_q <= 1'b0;
        gap_cnt_q <= gap_load;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            if (miss && owned && gap_cnt_q == 10'h000)
            begin
              state_q <= S_SEND;
              cfg_dirty_q <= cfg_wr;
              act_div_q <= div_use;
              act_wide_q <= cfg_wide_q;
              cs_sel_q <= want_sel;
              cs_on_q <= 1'b1;
              tx_q <= tx_load;
              bit_cnt_q <= nbits;
              div_cnt_q <= 5'h00;
              sclk_q <= 1'b0;
              fetch_q <= rd_word;
            end
          end
          S_SEND, S_DATA:
          begin
            if (bit_end)
            begin
              div_cnt_q <= 5'h00;
              sclk_q <= 1'b0;
              tx_q <= {tx_q[46:0], 1'b0};
              bit_cnt_q <= bit_cnt_q - 6'h01;
              if (state_q == S_DATA)
                rx_q <= rx_next;
              if (bit_cnt_q == 6'h00)
              begin
                if (state_q == S_SEND)
                begin
                  state_q <= S_DATA;
                  bit_cnt_q <= `SFB_WORD_BITS;
                end
                else
                begin
                  state_q <= S_HOLD;
                  buf_q <= word_le;
                  buf_word_q <= fetch_q;
                  buf_valid_q <= !cfg_wr;
                  fetch_q <= fetch_inc;
                end
              end
            end
            else
            begin
              div_cnt_q <= div_cnt_q + 5'h01;
              if (div_cnt_q + 5'h01 == half)
                sclk_q <= 1'b1;
            end
          end
          S_HOLD:
          begin
            if (!buf_valid_q || hit || (want && rd_word == fetch_q))
            begin
              state_q <= S_DATA;
              bit_cnt_q <= `SFB_WORD_BITS;
              div_cnt_q <= 5'h00;
              if (want && rd_word == fetch_q)
                buf_valid_q <= 1'b0;
            end
          end
          default:
          begin
            state_q <= S_IDLE;
            cs_on_q <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_clk <= 1'b0;
      flash_clk_oe_n <= 1'b1;
      flash_do <= 1'b0;
      flash_do_oe_n <= 1'b1;
      flash_select_n <= 4'hf;
      flash_select_oe_n <= 4'hf;
      manual_data_in_level <= 1'b0;
    end
    else if (clk_en)
    begin
      manual_data_in_level <= serial_data_in;
      if (manual_pin_enable)
      begin
        flash_clk <= man_clk;
        flash_clk_oe_n <= man_clk_oe_n;
        flash_do <= man_do;
        flash_do_oe_n <= man_do_oe_n;
        flash_select_n <= man_select_n;
        flash_select_oe_n <= man_select_oe_n;
      end
      else if (owned)
      begin
        flash_clk <= sclk_q;
        flash_clk_oe_n <= 1'b0;
        flash_do <= tx_q[47];
        flash_do_oe_n <= 1'b0;
        flash_select_n <= ~({3'h0, cs_on_q} << cs_sel_q);
        flash_select_oe_n <= 4'h0;
      end
      else
      begin
        flash_clk <= 1'b0;
        flash_clk_oe_n <= 1'b1;
        flash_do <= 1'b0;
        flash_do_oe_n <= 1'b1;
        flash_select_n <= 4'hf;
        flash_select_oe_n <= 4'hf;
      end
    end
  end

endmodule // sfb_reader
`default_nettype wire

// ===== sfb_reader_properties.sv
// Port assertions for the serial-flash boot reader
`timescale 1ns/1ps
`default_nettype none
`include "sfb_map.vh"
module sfb_props (
  input wire sys_clk,
  input wire rst,
  input wire rd_ack,
  input wire rd_err,
  input wire [31:0] rd_data,
  input wire wr_req,
  input wire wr_err,
  input wire [10:0] flash_read_config,
  input wire [1:0] si_owner,
  input wire manual_pin_enable,
  input wire man_clk,
  input wire flash_clk,
  input wire [3:0] flash_select_n,
  input wire [3:0] flash_select_oe_n
);
  logic [9:0] hi_q;
  // Cycles with every select high
  always @(posedge sys_clk or posedge rst)
    if (rst)
      hi_q <= 10'h3ff;
    else if (!(&flash_select_n))
      hi_q <= 10'h0;
    else if (hi_q != 10'h3ff)
      hi_q <= hi_q + 10'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_gap;
    !manual_pin_enable && $fell(&flash_select_n) |->
      hi_q >= flash_read_config[10:7] * flash_read_config[4:0];
  endproperty
  property p_own;
    !manual_pin_enable && si_owner != `SFB_OWNER_BOOT && $past(si_owner) != `SFB_OWNER_BOOT
      |-> &flash_select_oe_n;
  endproperty
  property p_man;
    manual_pin_enable && $past(manual_pin_enable) |-> flash_clk == $past(man_clk);
  endproperty
  property p_wide;
    flash_read_config[5] && !manual_pin_enable |-> &flash_select_n[3:1];
  endproperty
  a_one_select: assert property ($countones(~flash_select_n) <= 1)
    else $error("two selects low");
  a_write_refused: assert property (wr_req |=> wr_err)
    else $error("no write refusal");
  a_err_zero: assert property (rd_err |-> rd_ack && rd_data == 32'h0)
    else $error("bad error answer");
  a_ack_pulse: assert property (rd_ack |=> !rd_ack)
    else $error("ack too long");
  a_manual_clk: assert property (p_man)
    else $error("manual clock lost");
  a_gap_held: assert property (p_gap)
    else $error("deselect gap short");
  a_owner_only: assert property (p_own)
    else $error("pins driven unowned");
  a_wide_zero: assert property (p_wide)
    else $error("wide mode off select zero");
  c_err: cover property (rd_err);
  c_wr: cover property (wr_err);
  c_sel: cover property ($fell(&flash_select_n));
endmodule // sfb_props
`default_nettype wire

// ===== sfb_flash_model.sv
// Behavioural serial flash answering reads
`timescale 1ns/1ps
`default_nettype none
module sfb_flash_model (
  input wire clk,
  input wire mosi,
  input wire [3:0] sel_n,
  input wire wide,
  output logic miso
);
  logic [7:0] cmd = 0, b;
  logic [31:0] ad = 0, t;
  logic [3:0] selc;
  int n = 0, k;
  initial miso = 0;
  // Released line keeps changing
  always #7 if (&sel_n) miso = ~miso;
  always @(negedge (&sel_n))
  begin
    n = 0;
    ad = 0;
    selc = sel_n;
  end
  always @(posedge clk)
    if (!(&sel_n))
    begin
      if (n < 8)
        cmd = {cmd[6:0], mosi};
      else if (n < (wide ? 40 : 32))
        ad = {ad[30:0], mosi};
      n++;
    end
  // Data changes on falling clock
  always @(negedge clk)
  begin
    k = n - (wide ? 40 : 32) - (cmd == 8'h0b ? 8 : 0);
    t = ad + k / 8;
    b = t[7:0] ^ t[15:8] ^ 8'h5a;
    miso = (!(&sel_n) && k >= 0) ? b[7 - k % 8] : ~miso;
  end
endmodule // sfb_flash_model
`default_nettype wire

// ===== sfb_reader_tb.sv
// Testbench for the serial-flash boot reader
`timescale 1ns/1ps
`default_nettype none
`include "sfb_map.vh"
module sfb_reader_tb;
  logic sys_clk = 0, rst = 1, rd_req = 0, wr_req = 0, cfg_wr = 0, manual_pin_enable = 0;
  logic man_clk = 0, man_do = 0, cfg_wide_address_enable = 0, cfg_quick_read_enable = 0;
  logic man_clk_oe_n = 1, man_do_oe_n = 1;
  logic [27:0] rd_addr = 0, a;
  logic [1:0] rd_size = 0, si_owner = 0;
  logic [4:0] cfg_clk_div = 5'h1f;
  logic [3:0] cfg_select_idle_gap = 4'hf, man_select_n = 4'hf, man_select_oe_n = 4'hf;
  wire rd_ack, rd_err, wr_err, manual_data_in_level, flash_clk, flash_do, serial_data_in;
  wire busy, flash_clk_oe_n, flash_do_oe_n;
  wire [31:0] rd_data;
  wire [10:0] flash_read_config;
  wire [3:0] flash_select_n, flash_select_oe_n;
  int mismatches = 0, num_checks = 0, cyc = 0, lat, o;
  sfb_reader sfb_reader_inst (.sys_clk, .rst, .clk_en(1'b1), .rd_req, .rd_addr, .rd_size,
    .rd_ack, .rd_err, .rd_data, .wr_req, .wr_err, .cfg_wr, .cfg_clk_div,
    .cfg_wide_address_enable, .cfg_quick_read_enable, .cfg_select_idle_gap,
    .flash_read_config, .si_owner, .busy, .manual_pin_enable, .man_clk,
    .man_clk_oe_n, .man_do, .man_do_oe_n, .man_select_n, .man_select_oe_n,
    .manual_data_in_level, .flash_clk, .flash_clk_oe_n, .flash_do, .flash_do_oe_n,
    .flash_select_n, .flash_select_oe_n, .serial_data_in);
  sfb_flash_model fm (.clk(flash_clk), .mosi(flash_do), .sel_n(flash_select_n),
    .wide(cfg_wide_address_enable), .miso(serial_data_in));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (++cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [47:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] fb(input logic [27:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [31:0] ew(input logic [27:0] x, input logic [1:0] sz);
    logic [31:0] w;
    w = {fb(x | 28'h3), fb(x | 28'h2), fb(x | 28'h1), fb(x & ~28'h3)};
    if (sz == `SFB_SIZE_BYTE)
      w &= 32'hff << (8 * x[1:0]);
    else if (sz == `SFB_SIZE_HALF)
      w &= 32'hffff << (8 * x[1:0]);
    return w;
  endfunction
  task rd(input logic [27:0] ad, input logic [1:0] sz, input logic [31:0] e, input logic er);
    @(negedge sys_clk);
    rd_addr = ad;
    rd_size = sz;
    rd_req = 1;
    lat = 0;
    do
    begin
      @(negedge sys_clk);
      lat++;
    end
    while (rd_ack !== 1 && lat < 5000);
    chk({rd_ack, rd_err, rd_data}, {1'b1, er, e});
    rd_req = 0;
  endtask
  task cfg(input logic [4:0] d, input logic w, q, input logic [3:0] g);
    @(negedge sys_clk);
    cfg_clk_div = d;
    cfg_wide_address_enable = w;
    cfg_quick_read_enable = q;
    cfg_select_idle_gap = g;
    cfg_wr = 1;
    @(negedge sys_clk);
    cfg_wr = 0;
    repeat (2) @(negedge sys_clk);
    chk(flash_read_config, {g, q, w, d});
  endtask
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 0;
    repeat (3) @(negedge sys_clk);
    chk(flash_read_config, 11'h79f);
    rd_addr = 28'h10;
    rd_size = 2'h2;
    rd_req = 1;
    repeat (60) @(negedge sys_clk);
    chk({rd_ack, busy, flash_clk_oe_n, flash_do_oe_n, flash_select_oe_n}, 8'h3f);
    si_owner = `SFB_OWNER_BOOT;
    rd(28'h10, 2'h2, ew(28'h10, 2'h2), 0);
    chk({fm.cmd, fm.ad, fm.selc, busy}, {8'h03, 32'h10, 4'he, 1'b1});
    repeat (1200) @(negedge sys_clk);
    rd(28'h14, 2'h2, ew(28'h14, 2'h2), 0);
    chk(lat < 3, 1);
    cfg(5'h2, 0, 0, 4'h2);
    rd(28'h18, 2'h2, ew(28'h18, 2'h2), 0);
    for (int s = 0; s < 4; s++)
    begin
      o = s == 0 ? 3 : s == 1 ? 2 : 0;
      a = {2'h0, s[1:0], 22'h40, o[1:0]};
      rd(a, s[1:0], ew(a, s[1:0]), 0);
      chk({fm.selc, fm.ad}, {~(4'h1 << s), 32'h100});
    end
    rd(28'h4000000, 2'h2, 32'h0, 1);
    @(negedge sys_clk);
    wr_req = 1;
    @(negedge sys_clk);
    wr_req = 0;
    chk(wr_err, 1);
    cfg(5'h2, 0, 1, 4'h1);
    rd(28'h200, 2'h2, ew(28'h200, 2'h2), 0);
    chk(fm.cmd, 8'h0b);
    cfg(5'h2, 1, 1, 4'h1);
    rd(28'h3000010, 2'h2, ew(28'h3000010, 2'h2), 0);
    chk({fm.cmd, fm.selc, fm.ad}, {8'h0b, 4'he, 32'h3000010});
    man_select_oe_n = 4'h0;
    man_select_n = 4'hd;
    man_clk = 1;
    man_do = 1;
    man_clk_oe_n = 0;
    manual_pin_enable = 1;
    repeat (3) @(negedge sys_clk);
    chk({flash_clk, flash_do, flash_select_n, flash_select_oe_n, flash_clk_oe_n, flash_do_oe_n},
      12'hf41);
    chk(manual_data_in_level, serial_data_in);
    conclude();
  end
endmodule // sfb_reader_tb
bind sfb_reader sfb_props sfb_props_inst (.sys_clk, .rst, .rd_ack, .rd_err, .rd_data,
  .wr_req, .wr_err, .flash_read_config, .si_owner, .manual_pin_enable, .man_clk,
  .flash_clk, .flash_select_n, .flash_select_oe_n);
`default_nettype wire
